// ==== logic/eif_defs.vh ====
// Purpose: Constants for the external interrupt noise filter front end.
// Assumes: 32-bit APB register words, byte offsets below.
// Notes: Definitions only.
`ifndef EIF_DEFS_VH
`define EIF_DEFS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define EIF_OFS_GATE 8'h00
`define EIF_OFS_CTRL1 8'h04
`define EIF_OFS_CTRL2 8'h08
`define EIF_OFS_CTRL3 8'h0c
`define EIF_OFS_CTRL4 8'h10
`define EIF_OFS_ENABLE 8'h14
`define EIF_OFS_LATCH 8'h18

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define EIF_CTRL_NC_LSB 0
`define EIF_CTRL_ES_LSB 2
`define EIF_CTRL_LVL_BIT 4
`define EIF_ENABLE_MASTER_BIT 6
`define EIF_GATE_RESET 6'h00
`define EIF_ES_RESET 2'h0
`define EIF_NC_RESET 2'h0
`define EIF_ENABLE_RESET 7'h00

// ****************************************************************
// Encodings
// ****************************************************************
`define EIF_ES_RISE 2'h0
`define EIF_ES_FALL 2'h1
`define EIF_ES_BOTH 2'h2
`define EIF_ES_HIGH 2'h3
`define EIF_NC_DIV1 2'h0
`define EIF_NC_DIV4 2'h1
`define EIF_NC_DIV8 2'h2
`define EIF_NC_DIV16 2'h3
`define EIF_MODE_FAST 2'h1
`define EIF_MODE_SLOW 2'h2

// ****************************************************************
// Timing counts
// ****************************************************************
`define EIF_FAST_CFG_SAMPLES 3
`define EIF_FAST_FIXED_SAMPLES 2
`define EIF_SLOW_SAMPLES 2
`define EIF_SLOW_DIVIDE 4
`define EIF_FS_QUARTER 2'h3

`endif

// ==== logic/eif_noise_filter.v ====
// Purpose: Six-source external interrupt front end with noise filters and an APB register file.
// Assumes: pclk is the gear clock; low_freq_clock and the pins are asynchronous to it.
// Notes: Sources zero and five are fixed falling-edge; one to four are configurable.
//
// What this block does
// - Sources zero and five request on each filtered falling edge of their pin.
// - Fast modes: fixed sources reject one-clock pulses, accept two clocks or more.
// - Slow modes: fixed sources reject under four, accept eight low-frequency periods.
// - Fast modes: configurable sources reject under two samples, accept over three.
// - A clock-gate bit at zero stops its source; one makes it usable.
// - Reset clears every clock-gate bit to zero.
// - Sources one to three: 00 rise, 01 fall, 10 both, 11 reserved.
// - Source four uses same codes, and 11 requests while filtered level high.
// - Sources one to four: filtered level is captured into a readable bit when a request fires.
// - The captured level bit refreshes on every new request of that source.
// - Fast modes: a configurable source's level is accepted after three equal consecutive samples.
// - Sampling interval field: 00 clock, 01 divide 4, 10 divide 8, 11 divide 16.
// - Slow modes: sample at low-frequency clock over four, two equal samples.
// - Deep modes halt sampling and requests; sampling resumes in other modes.
// - A pin switched to output mode is seen low by its detector.
// - Bits seven to five of each source control register read as zero.
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "eif_defs.vh"

module eif_noise_filter #(
  parameter NUM_SRC = 6
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  input wire fixed_irq_pin_zero,
  input wire config_irq_pin_one,
  input wire config_irq_pin_two,
  input wire config_irq_pin_three,
  input wire config_irq_pin_four,
  input wire fixed_irq_pin_five,
  input wire [5:0] pin_output_mode,
  input wire [1:0] operating_mode,
  input wire low_freq_clock,
  output wire [5:0] irq_request,
  output wire irq_service
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  // Control fields of source i sit at bits 2i+1:2i of nc_all and es_all.
  reg [5:0] power_gate_control;
  reg [11:0] nc_all;
  reg [11:0] es_all;
  reg [5:0] individual_enable_flag;
  reg master_irq_enable;
  reg [5:0] pending;
  wire [5:0] captured_level_bit;

  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr_take = access & pwrite;
  wire hit_gate = (paddr == `EIF_OFS_GATE);
  wire hit_ctrl1 = (paddr == `EIF_OFS_CTRL1);
  wire hit_ctrl2 = (paddr == `EIF_OFS_CTRL2);
  wire hit_ctrl3 = (paddr == `EIF_OFS_CTRL3);
  wire hit_ctrl4 = (paddr == `EIF_OFS_CTRL4);
  wire hit_enable = (paddr == `EIF_OFS_ENABLE);
  wire hit_latch = (paddr == `EIF_OFS_LATCH);
  wire mapped = hit_gate | hit_ctrl1 | hit_ctrl2 | hit_ctrl3 | hit_ctrl4 |
                hit_enable | hit_latch;

  // Zero wait states: the read word is built in the setup cycle.
  assign pready = access;

  function [31:0] ctrl_word;
    input [1:0] nc;
    input [1:0] es;
    input lvl;
    begin
      ctrl_word = 32'h0000_0000;
      ctrl_word[`EIF_CTRL_NC_LSB +: 2] = nc;
      ctrl_word[`EIF_CTRL_ES_LSB +: 2] = es;
      ctrl_word[`EIF_CTRL_LVL_BIT] = lvl;
    end
  endfunction

  // Unmapped reads return zero with the error flag set, and writes to them are dropped.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= ~mapped;
      if (hit_gate) begin
        prdata <= {26'h0, power_gate_control};
      end else if (hit_ctrl1) begin
        prdata <= ctrl_word(nc_all[3:2], es_all[3:2], captured_level_bit[1]);
      end else if (hit_ctrl2) begin
        prdata <= ctrl_word(nc_all[5:4], es_all[5:4], captured_level_bit[2]);
      end else if (hit_ctrl3) begin
        prdata <= ctrl_word(nc_all[7:6], es_all[7:6], captured_level_bit[3]);
      end else if (hit_ctrl4) begin
        prdata <= ctrl_word(nc_all[9:8], es_all[9:8], captured_level_bit[4]);
      end else if (hit_enable) begin
        prdata <= {25'h0, master_irq_enable, individual_enable_flag};
      end else if (hit_latch) begin
        prdata <= {26'h000_0000, pending};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_gate_control <= `EIF_GATE_RESET;
      nc_all <= 12'h000;
      es_all <= 12'h000;
      individual_enable_flag <= 6'h00;
      master_irq_enable <= 1'b0;
    end else begin
      // Fixed sources always look for a falling edge, sampling at full rate in fast modes.
      nc_all[1:0] <= `EIF_NC_DIV1;
      nc_all[11:10] <= `EIF_NC_DIV1;
      es_all[1:0] <= `EIF_ES_FALL;
      es_all[11:10] <= `EIF_ES_FALL;
      if (wr_take) begin
        if (hit_gate) begin
          power_gate_control <= pwdata[5:0];
        end else if (hit_ctrl1) begin
          nc_all[3:2] <= pwdata[`EIF_CTRL_NC_LSB +: 2];
          es_all[3:2] <= pwdata[`EIF_CTRL_ES_LSB +: 2];
        end else if (hit_ctrl2) begin
          nc_all[5:4] <= pwdata[`EIF_CTRL_NC_LSB +: 2];
          es_all[5:4] <= pwdata[`EIF_CTRL_ES_LSB +: 2];
        end else if (hit_ctrl3) begin
          nc_all[7:6] <= pwdata[`EIF_CTRL_NC_LSB +: 2];
          es_all[7:6] <= pwdata[`EIF_CTRL_ES_LSB +: 2];
        end else if (hit_ctrl4) begin
          nc_all[9:8] <= pwdata[`EIF_CTRL_NC_LSB +: 2];
          es_all[9:8] <= pwdata[`EIF_CTRL_ES_LSB +: 2];
        end else if (hit_enable) begin
          individual_enable_flag <= pwdata[5:0];
          master_irq_enable <= pwdata[`EIF_ENABLE_MASTER_BIT];
        end
      end
    end
  end

  // ****************************************************************
  // Interrupt latch
  // ****************************************************************
  // Writing a one clears a latch bit; a zero leaves that bit alone.
  // A request arriving in the clearing cycle survives: the set term is ORed last.
  wire [5:0] latch_clear = (wr_take & hit_latch) ? pwdata[5:0] : 6'h00;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= 6'h00;
    end else begin
      pending <= (pending & ~latch_clear) | irq_request;
    end
  end

  // Service is a plain level; priority among sources is left to the core.
  assign irq_service = master_irq_enable & |(pending & individual_enable_flag);

  // ****************************************************************
  // Sampling time base
  // ****************************************************************
  wire mode_fast = (operating_mode == `EIF_MODE_FAST);
  wire mode_slow = (operating_mode == `EIF_MODE_SLOW);
  // The divider runs free, so the first sample after an interval change may come early.
  // The slow clock is resynchronised here and only its rising edges are counted.
  reg [3:0] div_cnt;
  reg fs_s1;
  reg fs_s2;
  reg fs_s3;
  reg [1:0] fs_quarter;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 4'h0;
      fs_s1 <= 1'b0;
      fs_s2 <= 1'b0;
      fs_s3 <= 1'b0;
      fs_quarter <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
      fs_s1 <= low_freq_clock;
      fs_s2 <= fs_s1;
      fs_s3 <= fs_s2;
      if (fs_s2 & ~fs_s3) begin
        fs_quarter <= fs_quarter + 2'h1;
      end
    end
  end

  // One pulse per four low-frequency periods.
  wire slow_tick = fs_s2 & ~fs_s3 & (fs_quarter == `EIF_FS_QUARTER);

  function div_tick;
    input [1:0] nc;
    input [3:0] cnt;
    begin
      if (nc == `EIF_NC_DIV1) begin
        div_tick = 1'b1;
      end else if (nc == `EIF_NC_DIV4) begin
        div_tick = (cnt[1:0] == 2'h3);
      end else if (nc == `EIF_NC_DIV8) begin
        div_tick = (cnt[2:0] == 3'h7);
      end else begin
        div_tick = (cnt == 4'hf);
      end
    end
  endfunction

  // ****************************************************************
  // Per-source filter and detector
  // ****************************************************************
  wire [5:0] pins = {fixed_irq_pin_five, config_irq_pin_four, config_irq_pin_three,
                     config_irq_pin_two, config_irq_pin_one, fixed_irq_pin_zero};

  genvar i;
  generate
    for (i = 0; i < NUM_SRC; i = i + 1) begin : g_src
      localparam CFG = (i >= 1) && (i <= 4);
      localparam LEVEL_OK = (i == 4);
      // Synchroniser and filter start high so a pin resting high gives no edge after reset.
      reg s1;
      reg s2;
      reg [1:0] hist;
      reg filt;
      reg filt_d;
      reg cap;
      wire [1:0] nc = nc_all[2*i +: 2];
      wire [1:0] es = es_all[2*i +: 2];
      // Gating freezes the filter rather than clearing it, so a source that is gated on
      // again resumes from its last accepted level and may see an edge if the pin moved.
      wire live = power_gate_control[i] & (mode_fast | mode_slow);
      // A pin in output mode reads low at the detector.
      wire din = s2 & ~pin_output_mode[i];
      wire tick = live & (mode_fast ? div_tick(nc, div_cnt) : slow_tick);
      // Configurable sources need three equal samples in fast modes, all others two.
      wire need3 = mode_fast & CFG;
      wire stable = need3 ? ((hist[1] == din) && (hist[0] == din)) : (hist[0] == din);
      wire rise = filt & ~filt_d;
      wire fall = ~filt & filt_d;
      reg req;

      always @* begin
        req = 1'b0;
        if (live) begin
          case (es)
            `EIF_ES_RISE: req = rise;
            `EIF_ES_FALL: req = fall;
            `EIF_ES_BOTH: req = rise | fall;
            default: req = LEVEL_OK & filt;
          endcase
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1 <= 1'b1;
          s2 <= 1'b1;
          hist <= 2'h3;
          filt <= 1'b1;
          filt_d <= 1'b1;
          cap <= 1'b0;
        end else begin
          s1 <= pins[i];
          s2 <= s1;
          filt_d <= filt;
          if (tick) begin
            hist <= {hist[0], din};
            if (stable) begin
              filt <= din;
            end
          end
          if (req) begin
            cap <= filt;
          end
        end
      end

      assign irq_request[i] = req;
      assign captured_level_bit[i] = cap;
    end
  endgenerate

endmodule

// ==== dv/eif_pin_src.sv ====
// Purpose: Far-side model of the six external interrupt sources.
// Assumes: Pins idle high; the bench commands each level.
// Notes: Pins move a few ns after the command, out of step with pclk.
`timescale 1ns/1ps
module eif_pin_src (
  input wire [5:0] want,
  output reg [5:0] pin
);
  initial pin = 6'h3f;
  // Real sources are asynchronous, so edges never line up with the clock.
  always @(want) pin <= #7 want;
endmodule

// ==== dv/eif_noise_filter_props.sv ====
// Purpose: Port-level checks of the external interrupt filter.
// Assumes: All register writes arrive through the APB port.
// Notes: Gate and master enable bits are shadowed from bus writes.
`timescale 1ns/1ps
`include "eif_defs.vh"
module eif_noise_filter_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire fixed_irq_pin_zero,
  input wire fixed_irq_pin_five,
  input wire [1:0] operating_mode,
  input wire [5:0] irq_request,
  input wire irq_service
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  reg [5:0] gate_seen;
  reg master_seen;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_seen <= 6'h00;
      master_seen <= 1'b0;
    end else if (psel && penable && pwrite) begin
      if (paddr == `EIF_OFS_GATE) gate_seen <= pwdata[5:0];
      if (paddr == `EIF_OFS_ENABLE) master_seen <= pwdata[6];
    end
  end
  property p_ctrl_top_zero;
    psel && penable && !pwrite && paddr >= 8'h04 && paddr <= 8'h10 |-> prdata[7:5] == 3'h0;
  endproperty
  a_ctrl_top_zero: assert property (p_ctrl_top_zero) else $error("control top bits not zero");
  property p_zero_glitch;
    fixed_irq_pin_zero[*8] ##1 !fixed_irq_pin_zero ##1 fixed_irq_pin_zero
      |-> (!irq_request[0])[*6];
  endproperty
  a_zero_glitch: assert property (p_zero_glitch) else $error("source zero took a glitch");
  property p_five_glitch;
    fixed_irq_pin_five[*8] ##1 !fixed_irq_pin_five ##1 fixed_irq_pin_five
      |-> (!irq_request[5])[*6];
  endproperty
  a_five_glitch: assert property (p_five_glitch) else $error("source five took a glitch");
  property p_zero_fall;
    $fell(fixed_irq_pin_zero) && gate_seen[0] && operating_mode == `EIF_MODE_FAST
      ##1 !fixed_irq_pin_zero |-> ##[1:6] irq_request[0];
  endproperty
  a_zero_fall: assert property (p_zero_fall) else $error("source zero missed a fall");
  property p_all_gated;
    (gate_seen == 6'h00)[*3] |-> irq_request == 6'h00;
  endproperty
  a_all_gated: assert property (p_all_gated) else $error("request while all gated");
  property p_zero_gated;
    (!gate_seen[0])[*3] |-> !irq_request[0];
  endproperty
  a_zero_gated: assert property (p_zero_gated) else $error("request from gated source");
  property p_deep_quiet;
    (operating_mode == 2'h0 || operating_mode == 2'h3)[*3] |-> irq_request == 6'h00;
  endproperty
  a_deep_quiet: assert property (p_deep_quiet) else $error("request in deep mode");
  property p_no_master;
    !master_seen |-> !irq_service;
  endproperty
  a_no_master: assert property (p_no_master) else $error("service without master");
endmodule
bind eif_noise_filter eif_noise_filter_props u_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .fixed_irq_pin_zero(fixed_irq_pin_zero),
  .fixed_irq_pin_five(fixed_irq_pin_five),
  .operating_mode(operating_mode),
  .irq_request(irq_request),
  .irq_service(irq_service)
);

// ==== dv/eif_noise_filter_test.sv ====
// Purpose: Self-checking bench of the external interrupt filter.
// Assumes: Register reads are noted in order and compared on completion.
// Notes: Interrupt outcomes are observed through the latch register and the service output.
`timescale 1ns/1ps
`include "eif_defs.vh"
module eif_noise_filter_test;
  reg pclk, presetn, psel, penable, pwrite, lfclk;
  reg [7:0] paddr, ca;
  reg [31:0] pwdata;
  reg [5:0] want, pin_output_mode;
  reg [1:0] operating_mode, nc;
  wire pready, pslverr, irq_service;
  wire [31:0] prdata;
  wire [5:0] pins, irq_request;
  logic [32:0] notes[$];
  logic [4:1] lv;
  logic f, r;
  int n_mismatch, comparisons, s, e;
  eif_pin_src u_src (.want(want), .pin(pins));
  eif_noise_filter DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .fixed_irq_pin_zero(pins[0]), .config_irq_pin_one(pins[1]),
    .config_irq_pin_two(pins[2]), .config_irq_pin_three(pins[3]),
    .config_irq_pin_four(pins[4]), .fixed_irq_pin_five(pins[5]),
    .pin_output_mode(pin_output_mode), .operating_mode(operating_mode),
    .low_freq_clock(lfclk), .irq_request(irq_request), .irq_service(irq_service));
  always #12.5 pclk = ~pclk;
  // Odd half period keeps the slow clock off the pclk rising edges.
  always #131 lfclk = ~lfclk;
  task chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask
  task chk_svc(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: service %b, expected %b", $time, got, exp);
    end
  endtask
  always @(posedge pclk) if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, notes.pop_front());
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
    if (!w) notes.push_back(x);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task rd(input logic [7:0] a, input logic [32:0] x);
    apb(1'b0, a, 32'h0, x);
  endtask
  task setp(input int p, input logic v, input int n);
    want[p] <= v;
    repeat (n) @(posedge pclk);
  endtask
  task wrap_up;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, lfclk} = 6'h00;
    {paddr, pwdata, pin_output_mode} = 46'h0;
    want = 6'h3f;
    operating_mode = `EIF_MODE_FAST;
    lv = 4'h0;
    void'($urandom(32'h539e));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`EIF_OFS_GATE, 33'h0);
    rd(8'h1c, {1'b1, 32'h0});
    wr(`EIF_OFS_GATE, 32'h3f);
    wr(`EIF_OFS_ENABLE, 32'h41);
    rd(`EIF_OFS_ENABLE, 33'h41);
    for (s = 0; s < 6; s += 5) begin
      setp(s, 1'b0, 1);
      setp(s, 1'b1, 40);
      rd(`EIF_OFS_LATCH, 33'h0);
      setp(s, 1'b0, 2);
      setp(s, 1'b1, 40);
      rd(`EIF_OFS_LATCH, 33'h1 << s);
      chk_svc(irq_service, s == 0);
      wr(`EIF_OFS_LATCH, 32'h3f);
    end
    for (s = 1; s < 5; s++) begin
      for (e = 0; e < 4; e++) begin
        nc = 2'($urandom % 4);
        ca = 8'h04 + 8'(4 * (s - 1));
        f = (e == 1) || (e == 2) || (s == 4 && e == 3);
        r = (e == 0) || (e == 2) || (s == 4 && e == 3);
        wr(ca, {28'h0, e[1:0], nc});
        wr(`EIF_OFS_LATCH, 32'h3f);
        setp(s, 1'b0, 1);
        setp(s, 1'b1, 80);
        setp(s, 1'b0, 80);
        rd(`EIF_OFS_LATCH, 33'(f) << s);
        wr(`EIF_OFS_LATCH, 32'h3f);
        setp(s, 1'b1, 80);
        rd(`EIF_OFS_LATCH, 33'(r) << s);
        if (e == 1 || e == 2) lv[s] = 1'b0;
        if (r) lv[s] = 1'b1;
        rd(ca, {28'h0, lv[s], e[1:0], nc});
      end
    end
    wr(`EIF_OFS_ENABLE, 32'h40);
    wr(`EIF_OFS_CTRL4, 32'h0);
    operating_mode <= `EIF_MODE_SLOW;
    repeat (140) @(posedge pclk);
    wr(`EIF_OFS_LATCH, 32'h3f);
    setp(0, 1'b0, 30);
    setp(0, 1'b1, 300);
    rd(`EIF_OFS_LATCH, 33'h0);
    setp(0, 1'b0, 100);
    setp(0, 1'b1, 300);
    rd(`EIF_OFS_LATCH, 33'h1);
    operating_mode <= 2'h0;
    wr(`EIF_OFS_LATCH, 32'h3f);
    setp(0, 1'b0, 100);
    setp(0, 1'b1, 100);
    rd(`EIF_OFS_LATCH, 33'h0);
    operating_mode <= `EIF_MODE_FAST;
    repeat (60) @(posedge pclk);
    wr(`EIF_OFS_LATCH, 32'h3f);
    pin_output_mode <= 6'h01;
    repeat (40) @(posedge pclk);
    rd(`EIF_OFS_LATCH, 33'h1);
    pin_output_mode <= 6'h00;
    wr(`EIF_OFS_GATE, 32'h3e);
    wr(`EIF_OFS_LATCH, 32'h3f);
    setp(0, 1'b0, 40);
    setp(0, 1'b1, 40);
    rd(`EIF_OFS_LATCH, 33'h0);
    wrap_up();
  end
endmodule
